// ---- decim_filter.v ----
// Result FIFO and multichannel decimation filter core
`timescale 1ns/1ps
`include "decim_filter_defines.vh"

module result_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Pointer step with wrap after the last slot, shared by both pointers
  function [AW-1:0] ptr_step;
    input [AW-1:0] ptr;
    begin
      if (ptr == DEPTH[AW-1:0] - 1'b1) begin
        ptr_step = {AW{1'b0}};
      end else begin
        ptr_step = ptr + 1'b1;
      end
    end
  endfunction

  // Full ignores a pop in the same cycle: one slot of throughput for a shorter path
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // result_fifo

module decim_filter #(
  parameter CHANNELS = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control pins
  input wire sync_n,
  input wire mode_select,
  input wire clock_divide_select,
  // Modulators
  output wire modulator_sample_strobe,
  input wire [CHANNELS-1:0] modulator_bits,
  // Result strobe
  output wire result_strobe,
  output wire [CHANNELS*16-1:0] result_word,
  output wire settled,
  output wire quiet_window,
  output wire result_dropped,
  // Result stream
  output wire out_valid,
  input wire out_ready,
  output wire [CHANNELS*16-1:0] out_data
);
  localparam W = `CIC_WIDTH;

  // Scale and clamp to the 16-bit full-scale codes
  // Stage gain is 64 cubed, so a steady full-scale stream lands one code past the top
  function [15:0] saturate;
    input [W-1:0] acc;
    reg signed [W-1:0] scaled;
    begin
      scaled = $signed(acc) >>> `CIC_SHIFT;
      if (scaled > $signed({{(W-16){1'b0}}, `FS_POS})) begin
        saturate = `FS_POS;
      end else if (scaled < $signed({{(W-16){1'b1}}, `FS_NEG})) begin
        saturate = `FS_NEG;
      end else begin
        saturate = scaled[15:0];
      end
    end
  endfunction

  // Pin synchronisers
  // Pins are asynchronous, so only the second stage is read by logic
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  wire run;
  wire mode_low_power;
  wire cdiv;

  always @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {sync_n, mode_select, clock_divide_select};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign run = pin_sync_reg[2];
  assign mode_low_power = (pin_sync_reg[1] != `MODE_HIGH_SPEED);
  assign cdiv = pin_sync_reg[0];

  // Modulator tick divider
  reg [5:0] div_cnt_reg;
  wire [5:0] div_sel;
  reg tick_reg;

  // Master clocks per modulator tick for a mode and divide setting
  function [5:0] mod_divide;
    input low_power;
    input slow;
    begin
      if (low_power) begin
        mod_divide = slow ? `DIV_LP_SLOW : `DIV_LP_FAST;
      end else begin
        mod_divide = slow ? `DIV_HS_SLOW : `DIV_HS_FAST;
      end
    end
  endfunction

  assign div_sel = mod_divide(mode_low_power, cdiv);

  // A mode change mid-count wraps at once instead of running past the new limit
  always @(posedge clk) begin
    if (sys_rst || !run) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= div_sel - 6'h01) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
      tick_reg <= 1'b0;
    end
  end

  assign modulator_sample_strobe = tick_reg;

  // Shared decimation phase counter
  // One counter for every channel keeps all words on the same tick
  reg [5:0] phase_reg;
  wire dump;

  assign dump = tick_reg && (phase_reg == `DECIM_LAST);

  always @(posedge clk) begin
    if (sys_rst || !run) begin
      phase_reg <= 6'h00;
    end else if (tick_reg) begin
      phase_reg <= phase_reg + 6'h01;
    end
  end

  // Third-order comb-integrator per channel; its box-car kernel is symmetric
  wire [CHANNELS*16-1:0] chan_result;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      reg [W-1:0] int1_reg;
      reg [W-1:0] int2_reg;
      reg [W-1:0] int3_reg;
      reg [W-1:0] dly1_reg;
      reg [W-1:0] dly2_reg;
      reg [W-1:0] dly3_reg;
      wire [W-1:0] sample;
      wire [W-1:0] comb1;
      wire [W-1:0] comb2;
      wire [W-1:0] comb3;

      // Bit 1 counts as +1, bit 0 as -1
      assign sample = {{(W-1){~modulator_bits[g]}}, 1'b1};
      assign comb1 = int3_reg - dly1_reg;
      assign comb2 = comb1 - dly2_reg;
      // Image rejection deepens with stage count; three stages keep the adders narrow
      assign comb3 = comb2 - dly3_reg;
      assign chan_result[g*16 +: 16] = saturate(comb3);

      always @(posedge clk) begin
        if (sys_rst || !run) begin
          int1_reg <= {W{1'b0}};
          int2_reg <= {W{1'b0}};
          int3_reg <= {W{1'b0}};
          dly1_reg <= {W{1'b0}};
          dly2_reg <= {W{1'b0}};
          dly3_reg <= {W{1'b0}};
        end else begin
          if (tick_reg) begin
            int1_reg <= int1_reg + sample;
            int2_reg <= int2_reg + int1_reg;
            int3_reg <= int3_reg + int2_reg;
          end
          if (dump) begin
            dly1_reg <= int3_reg;
            dly2_reg <= comb1;
            dly3_reg <= comb2;
          end
        end
      end
    end
  endgenerate

  // Output word, strobe and settling count
  reg [CHANNELS*16-1:0] result_reg;
  reg strobe_reg;
  reg [6:0] conv_cnt_reg;
  reg [6:0] conv_cnt_next;
  reg settled_reg;
  reg quiet_reg;
  reg dropped_reg;
  wire fifo_in_ready;

  // Word count since the run began; it stops at the settling count
  always @* begin
    if (!run) begin
      conv_cnt_next = 7'h00;
    end else if (dump && conv_cnt_reg != `SETTLE_CONV) begin
      conv_cnt_next = conv_cnt_reg + 7'h01;
    end else begin
      conv_cnt_next = conv_cnt_reg;
    end
  end

  // Settled and quiet flags are judged on the next count so they move with the word strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      result_reg <= {(CHANNELS*16){1'b0}};
      strobe_reg <= 1'b0;
      conv_cnt_reg <= 7'h00;
      settled_reg <= 1'b0;
      quiet_reg <= 1'b1;
      dropped_reg <= 1'b0;
    end else begin
      strobe_reg <= dump;
      if (dump) begin
        result_reg <= chan_result;
      end
      conv_cnt_reg <= conv_cnt_next;
      settled_reg <= (conv_cnt_next == `SETTLE_CONV);
      quiet_reg <= (conv_cnt_next < `QUIET_CONV);
      // Words are not held back: a full FIFO loses the new word and flags it
      if (strobe_reg && !fifo_in_ready) begin
        dropped_reg <= 1'b1;
      end
    end
  end

  assign result_strobe = strobe_reg;
  assign result_word = result_reg;
  assign settled = settled_reg;
  assign quiet_window = quiet_reg;
  assign result_dropped = dropped_reg;

  result_fifo #(
    .WIDTH(CHANNELS*16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(strobe_reg),
    .in_ready(fifo_in_ready),
    .in_data(result_reg),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule // decim_filter

// ---- decim_filter_chk.sv ----
// Port assertions for the decimation filter
`timescale 1ns/1ps
module decim_filter_chk (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Pins
  input wire sync_n,
  input wire mode_select,
  input wire clock_divide_select,
  // Outputs
  input wire modulator_sample_strobe,
  input wire result_strobe,
  input wire settled,
  input wire quiet_window
);
  reg [12:0] stab_reg, gap_reg, wgap_reg;
  reg [6:0] words_reg;
  wire [6:0] div = mode_select ? (clock_divide_select ? 7'h28 : 7'h08)
    : (clock_divide_select ? 7'h08 : 7'h04);
  wire [7:0] made = words_reg + result_strobe;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence res_pulse;
    result_strobe ##1 !result_strobe;
  endsequence
  // Pins cross a sync, so rates and counts are judged only once pins have rested
  always @(posedge clk) begin
    if (sys_rst || !sync_n || $changed(mode_select) || $changed(clock_divide_select)) begin
      stab_reg <= 13'h0000;
    end else if (stab_reg != 13'h1FFF) begin
      stab_reg <= stab_reg + 13'h0001;
    end
    if (sys_rst || !sync_n) begin
      words_reg <= 7'h00;
    end else if (result_strobe && words_reg != 7'h7F) begin
      words_reg <= words_reg + 7'h01;
    end
    gap_reg <= modulator_sample_strobe ? 13'h0001 : gap_reg + 13'h0001;
    wgap_reg <= result_strobe ? 13'h0001 : wgap_reg + 13'h0001;
  end
  chk_tick_pulse: assert property (modulator_sample_strobe |=> !modulator_sample_strobe)
    else $error("tick too long");
  chk_tick_rate: assert property (modulator_sample_strobe && stab_reg > 13'h005A |-> gap_reg == div)
    else $error("tick spacing wrong");
  chk_word_rate: assert property (result_strobe && stab_reg > 13'h14B4 |-> wgap_reg == {div, 6'h00})
    else $error("word spacing wrong");
  chk_result_tick: assert property (result_strobe |-> $past(modulator_sample_strobe))
    else $error("word not after tick");
  chk_result_pulse: assert property (result_strobe |-> res_pulse)
    else $error("word strobe too long");
  chk_sync_halt: assert property (!sync_n [*5] |-> !modulator_sample_strobe && !result_strobe)
    else $error("runs while halted");
  chk_settle_min: assert property (settled && stab_reg > 13'h0008 |-> made >= 8'h4C)
    else $error("settled too early");
  chk_quiet_open: assert property (stab_reg > 13'h0008 && made <= 8'h1D |-> quiet_window)
    else $error("quiet window closed early");
endmodule // decim_filter_chk

// ---- decim_filter_defines.vh ----
// Constants for the multichannel decimation filter
`ifndef DECIM_FILTER_DEFINES_VH
`define DECIM_FILTER_DEFINES_VH
`define DECIM_RATIO 7'h40
`define DECIM_LAST 6'h3F
`define DIV_HS_SLOW 6'h08
`define DIV_HS_FAST 6'h04
`define DIV_LP_SLOW 6'h28
`define DIV_LP_FAST 6'h08
`define MODE_HIGH_SPEED 1'b0
`define SETTLE_CONV 7'h4C
`define QUIET_CONV 7'h1E
`define CIC_SHIFT 3
`define FS_POS 16'h7FFF
`define FS_NEG 16'h8000
`define CIC_WIDTH 21
`endif

// ---- decim_filter_tb_top.sv ----
// Testbench top for the decimation filter
`timescale 1ns/1ps
module decim_filter_tb_top;
  logic clk = 0, sys_rst = 1, sync_n = 1, mode_select = 0, clock_divide_select = 0;
  logic out_ready = 1, level = 1;
  wire ms, rs, settled, quiet_window, result_dropped, out_valid;
  wire [7:0] bits;
  wire [127:0] result_word, out_data;
  int mismatches = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  decim_filter i_dut (.clk(clk), .sys_rst(sys_rst), .sync_n(sync_n), .mode_select(mode_select),
    .clock_divide_select(clock_divide_select), .modulator_sample_strobe(ms),
    .modulator_bits(bits), .result_strobe(rs), .result_word(result_word), .settled(settled),
    .quiet_window(quiet_window), .result_dropped(result_dropped), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  mod_source i_mod (.clk(clk), .modulator_sample_strobe(ms), .level(level),
    .modulator_bits(bits));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wait_hi(input logic sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel ? rs : ms) !== 1'b1 && n < 6000);
    if (n >= 6000) mismatches++;
  endtask
  task rate_case(input logic m, input logic d, input int n);
    int t0;
    @(posedge clk);
    mode_select <= m;
    clock_divide_select <= d;
    repeat (100) @(posedge clk);
    wait_hi(0);
    t0 = cyc;
    wait_hi(0);
    check(cyc - t0, n);
    wait_hi(1);
    t0 = cyc;
    wait_hi(1);
    check(cyc - t0, 64 * n);
  endtask
  task full_scale(input logic lv, input logic [15:0] exp);
    @(posedge clk);
    sync_n <= 0;
    level <= lv;
    repeat (8) @(posedge clk);
    check(ms | rs, 0);
    sync_n <= 1;
    repeat (8) @(posedge clk);
    check(quiet_window, 1);
    repeat (77) wait_hi(1);
    check(settled, 1);
    check(quiet_window, 0);
    // Every lane must agree, since mod_source drives all eight channels from one level
    for (int g = 0; g < 8; g++) check(result_word[16*g +: 16], exp);
  endtask
  task fifo_fill;
    int n;
    @(posedge clk);
    out_ready <= 0;
    repeat (18) wait_hi(1);
    @(posedge clk);
    check(result_dropped, 1);
    check(out_data[15:0], 16'h8000);
    out_ready <= 1;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (out_valid === 1'b1) n++;
    end
    check(n, 16);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    rate_case(1, 1, 40);
    rate_case(1, 0, 8);
    rate_case(0, 1, 8);
    rate_case(0, 0, 4);
    full_scale(1, 16'h7FFF);
    full_scale(0, 16'h8000);
    fifo_fill;
    test_done;
  end
  initial begin
    #400000;
    mismatches++;
    test_done;
  end
endmodule // decim_filter_tb_top
bind decim_filter decim_filter_chk i_chk (.clk(clk), .sys_rst(sys_rst), .sync_n(sync_n),
  .mode_select(mode_select), .clock_divide_select(clock_divide_select),
  .modulator_sample_strobe(modulator_sample_strobe), .result_strobe(result_strobe),
  .settled(settled), .quiet_window(quiet_window));

// ---- mod_source.sv ----
// Modulator bitstream source
`timescale 1ns/1ps
module mod_source (
  // Clock
  input wire clk,
  // Tick and level
  input wire modulator_sample_strobe,
  input wire level,
  output reg [7:0] modulator_bits
);
  initial modulator_bits = 8'h00;
  // Bits move only after a tick, as a real modulator would
  always @(posedge clk) begin
    if (modulator_sample_strobe) begin
      modulator_bits <= {8{level}};
    end
  end
endmodule // mod_source
